// file: hdl/msg_fifo.sv
// Word FIFO between the message capture and the serial output shifter.
// Assumes DEPTH is a power of two; the memory itself is not reset.
`timescale 1ns/100ps
module msg_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Honest full and empty from the occupancy count
	assign o_in_ready = count != (AW+1)'(DEPTH);
	assign o_out_valid = count != '0;
	assign o_out_data = mem[rd_ptr];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Pointer and count updates
	always_comb begin
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage write
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end
endmodule : msg_fifo

// file: hdl/paging_mode_ctrl.sv
// Mode sequencer, programming port and message output of the paging decoder.
// Assumes a decoder core on i_clk supplying sync hits and corrected codewords;
// all pins from outside pass a two-stage synchroniser first.
`timescale 1ns/100ps

// Notes on behaviour
// - Reset release enters programming wait
// - Strobes beyond 128 are ignored
// - Data bit taken on strobe rising edge
// - After 128th strobe: catch or off
// - Off mode: only reference clock active
// - Receive enable switches reception anytime; in programming wait the code reads it only at the 128th strobe
// - Enable rise: radio and PLL on four batches
// - Then one-third on-time for retry batches
// - Sync found enters lock, else idle
// - Idle: 32-bit window per 576 bits
// - Sync in idle enters lock
// - Address match drives flag low, captures message
// - Message shifted out with strobe, format selectable
// - Address word, message words, termination word
// - Sync lost for hold time: back to catch
// - Reset low 2 ms clears configuration
// - Reset high 2 ms then reprogram
// - Enable high in reset: board test
// - Test: radio, PLL on; exit on reset high
// - Test: bitstream routed to buzzer
// - Message ends on first/second uncorrectable word
// - PLL leads by both delays, radio by first
module paging_mode_ctrl
	import paging_pkg::*;
#(
	parameter int P_BIT_CYCLES = BIT_CYCLES,
	parameter int P_RST_CYCLES = RST_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ext_reset_n,
	input wire logic i_prog_clk,
	input wire logic i_prog_serial_in,
	input wire logic i_rx_enable,
	input wire logic i_rx_bitstream_in,
	input wire logic i_sync_hit,
	input wire logic i_cw_valid,
	input wire logic [31:0] i_cw_word,
	input wire logic [2:0] i_cw_frame,
	input wire logic i_cw_uncorr,
	output logic o_cw_ready,
	output logic o_radio_power_en,
	output logic o_radio_quick_charge,
	output logic o_pll_power_en,
	output logic o_addr_match_flag_n,
	output logic o_msg_serial_out,
	output logic o_msg_clk_out,
	output logic o_sync_valid_out,
	output logic o_buzzer_out,
	output logic o_ref_clock_out
);
	localparam logic [16:0] BIT_LAST = 17'(P_BIT_CYCLES - 1);
	localparam logic [17:0] RST_LAST = 18'(P_RST_CYCLES - 1);
	localparam logic [10:0] REF_LAST = 11'(REF_HALF_CYCLES - 1);
	localparam logic [2:0] SER_LAST = 3'(MSG_HALF_CYCLES - 1);

	// Pin order: 0 reset, 1 strobe, 2 data, 3 enable, 4 bitstream
	logic [4:0] pin_s1, pin_s2, pin_d;
	mode_type mode, next_mode;
	logic [127:0] cfg, next_cfg;
	logic [7:0] prog_cnt, next_prog_cnt;
	logic [17:0] rst_cnt, next_rst_cnt;
	logic [16:0] bit_div, next_bit_div;
	logic [9:0] bit_cnt, next_bit_cnt, batch_cnt, next_batch_cnt;
	logic sync_seen, next_sync_seen, in_msg, next_in_msg;
	logic [1:0] uncorr, next_uncorr;
	logic term_pend, next_term_pend, push_valid, next_push_valid;
	logic [31:0] push_data, next_push_data, ser_shift, next_ser_shift;
	logic [5:0] ser_left, next_ser_left;
	logic [2:0] ser_div, next_ser_div;
	logic [10:0] ref_div, next_ref_div;
	logic next_cw_ready, next_radio, next_qc, next_pll, next_addr_n;
	logic next_msg_out, next_msg_clk, next_sync_valid, next_buzzer, next_ref;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [31:0] fifo_out_data;
	logic prog_rise, rxen, rxen_rise, rst_rise, held_low, held_high;
	logic bit_tick, batch_end, sync_hit, accept, active, ser_tick, radio_win, pll_win;
	logic [9:0] pre_a, pre_ab, on_bits, hold;
	logic [3:0] retries;

	// Address comparison against the four programmed pager addresses
	function automatic logic addr_hit(input logic [127:0] c, input logic [31:0] w,
		input logic [2:0] fr);
		logic hit;
		logic [17:0] a;
		logic [2:0] f;
		hit = 1'b0;
		a = '0;
		f = '0;
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 18; j++) begin
				a[17-j] = c[ADDR_POS + ADDR_STEP*k + j];
			end
			for (int j = 0; j < 3; j++) begin
				f[2-j] = c[FRAME_POS + ADDR_STEP*k + j];
			end
			if (c[EN_POS + k] && a == w[30:13] && f == fr) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : addr_hit

	// Two-stage synchronisers for every asynchronous pin
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_s1 <= 5'h01;
			pin_s2 <= 5'h01;
			pin_d <= 5'h01;
		end else begin
			pin_s1 <= {i_rx_bitstream_in, i_rx_enable, i_prog_serial_in, i_prog_clk,
				i_ext_reset_n};
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	// Pin edges, option decode and radio windows
	always_comb begin
		prog_rise = pin_s2[1] & ~pin_d[1];
		rxen = pin_s2[3];
		rxen_rise = pin_s2[3] & ~pin_d[3];
		rst_rise = pin_s2[0] & ~pin_d[0];
		held_low = ~pin_s2[0] && pin_s2[0] == pin_d[0] && rst_cnt == RST_LAST;
		held_high = pin_s2[0] && pin_s2[0] == pin_d[0] && rst_cnt == RST_LAST;
		active = mode == MODE_OFF || mode == MODE_CATCH1 || mode == MODE_CATCH2 ||
			mode == MODE_IDLE || mode == MODE_LOCK;
		bit_tick = bit_div == BIT_LAST;
		batch_end = bit_tick && bit_cnt == BATCH_LAST;
		sync_hit = i_sync_hit & o_radio_power_en;
		accept = i_cw_valid & o_cw_ready & (mode == MODE_LOCK);
		retries = {~cfg[TD3_POS], cfg[TD2_POS], cfg[TD1_POS], 1'b1};
		hold = cfg[EOUTR_POS] ? 10'h000 : 10'(HOLD_BASE << {cfg[HOLD1_POS], cfg[HOLD0_POS]});
		pre_a = {6'h00, cfg[PL2_POS], cfg[PL1_POS], 2'h2};
		pre_ab = 10'(pre_a + {4'h0, cfg[PL4_POS], cfg[PL3_POS], 4'h0});
		on_bits = (mode == MODE_CATCH2) ? CATCH2_ON_BITS : IDLE_ON_BITS;
		radio_win = bit_cnt < on_bits || bit_cnt >= 10'(BATCH_BITS - pre_a);
		pll_win = bit_cnt < on_bits || bit_cnt >= 10'(BATCH_BITS - pre_ab);
		ser_tick = ser_div == SER_LAST;
	end

	// Next-state logic for modes, programming, message capture and output
	always_comb begin
		next_mode = mode;
		next_cfg = cfg;
		next_prog_cnt = prog_cnt;
		next_rst_cnt = rst_cnt;
		next_bit_div = bit_tick ? 17'h00000 : 17'(bit_div + 1'b1);
		next_bit_cnt = bit_cnt;
		next_batch_cnt = batch_cnt;
		next_sync_seen = sync_seen;
		next_uncorr = uncorr;
		next_in_msg = in_msg;
		next_term_pend = term_pend;
		next_push_valid = push_valid & ~fifo_in_ready;
		next_push_data = push_data;
		// Reset pin level timer restarts on every change
		if (pin_s2[0] != pin_d[0]) begin
			next_rst_cnt = '0;
		end else if (rst_cnt != RST_LAST) begin
			next_rst_cnt = 18'(rst_cnt + 1'b1);
		end
		if (bit_tick) begin
			next_bit_cnt = batch_end ? 10'h000 : 10'(bit_cnt + 1'b1);
		end
		unique case (mode)
			MODE_PROG_WAIT: begin
				if (prog_rise && prog_cnt != PROG_BITS) begin
					next_cfg[prog_cnt[6:0]] = pin_s2[2];
					next_prog_cnt = 8'(prog_cnt + 1'b1);
					if (prog_cnt == PROG_LAST) begin
						next_mode = rxen ? MODE_CATCH1 : MODE_OFF;
						next_bit_cnt = '0;
						next_batch_cnt = '0;
					end
				end
			end
			MODE_OFF: begin
				if (rxen_rise) begin
					next_mode = MODE_CATCH1;
					next_bit_cnt = '0;
					next_batch_cnt = '0;
				end
			end
			MODE_CATCH1: begin
				if (sync_hit) begin
					next_mode = MODE_LOCK;
				end else if (batch_end) begin
					next_batch_cnt = 10'(batch_cnt + 1'b1);
					if (batch_cnt == CATCH1_LAST) begin
						next_mode = MODE_CATCH2;
						next_batch_cnt = '0;
					end
				end
			end
			MODE_CATCH2: begin
				if (sync_hit) begin
					next_mode = MODE_LOCK;
				end else if (batch_end) begin
					next_batch_cnt = 10'(batch_cnt + 1'b1);
					if (10'(batch_cnt + 1'b1) == {6'h00, retries}) begin
						next_mode = MODE_IDLE;
						next_batch_cnt = '0;
					end
				end
			end
			MODE_IDLE: begin
				if (sync_hit) begin
					next_mode = MODE_LOCK;
				end
			end
			MODE_LOCK: begin
				if (sync_hit) begin
					next_sync_seen = 1'b1;
				end
				if (batch_end) begin
					next_sync_seen = 1'b0;
					next_batch_cnt = 10'(batch_cnt + 1'b1);
					if (sync_seen || sync_hit) begin
						next_batch_cnt = '0;
					end else if (10'(batch_cnt + 1'b1) >= hold) begin
						next_mode = MODE_CATCH1;
						next_batch_cnt = '0;
						next_bit_cnt = '0;
					end
				end
			end
			MODE_RESET: begin
				if (rxen) begin
					next_mode = MODE_TEST;
				end else if (held_high) begin
					next_mode = MODE_PROG_WAIT;
					next_prog_cnt = '0;
				end
			end
			MODE_TEST: begin
				if (!rxen) begin
					next_mode = MODE_RESET;
				end else if (held_high) begin
					next_mode = MODE_PROG_WAIT;
					next_prog_cnt = '0;
				end
			end
		endcase
		if (next_mode == MODE_LOCK && mode != MODE_LOCK) begin
			next_sync_seen = 1'b1;
			next_batch_cnt = '0;
		end
		// Pin overrides: enable low, short reset pulse, long reset hold
		if (active && !rxen) begin
			next_mode = MODE_OFF;
		end
		if (rst_rise && mode != MODE_RESET && mode != MODE_TEST) begin
			next_mode = MODE_PROG_WAIT;
			next_prog_cnt = '0;
		end
		if (held_low && mode != MODE_RESET && mode != MODE_TEST) begin
			next_mode = MODE_RESET;
			next_cfg = '0;
			next_prog_cnt = '0;
		end
		// Codeword handling while locked
		if (accept) begin
			if (!in_msg) begin
				if (!i_cw_word[31] && addr_hit(cfg, i_cw_word, i_cw_frame)) begin
					next_in_msg = 1'b1;
					next_uncorr = '0;
					next_push_valid = 1'b1;
					next_push_data = i_cw_word;
				end
			end else if (i_cw_word[31]) begin
				if (i_cw_uncorr) begin
					next_uncorr = 2'(uncorr + 1'b1);
					if (uncorr[0] == cfg[OVER_POS]) begin
						next_term_pend = 1'b1;
					end
				end else begin
					next_push_valid = 1'b1;
					next_push_data = i_cw_word;
				end
			end else begin
				next_term_pend = 1'b1;
			end
		end
		if (in_msg && next_mode != MODE_LOCK) begin
			next_term_pend = 1'b1;
		end
		if (term_pend && !next_push_valid) begin
			next_push_valid = 1'b1;
			next_push_data = TERM_WORD;
			next_term_pend = 1'b0;
			next_in_msg = 1'b0;
		end
		next_cw_ready = ~next_push_valid & ~next_term_pend & (next_mode == MODE_LOCK);
		next_addr_n = ~next_in_msg;
		// Radio and PLL enables per mode
		unique case (mode)
			MODE_CATCH1, MODE_LOCK: begin
				next_radio = 1'b1;
				next_pll = 1'b1;
			end
			MODE_CATCH2, MODE_IDLE: begin
				next_radio = radio_win;
				next_pll = pll_win;
			end
			MODE_TEST: begin
				next_radio = rxen;
				next_pll = rxen;
			end
			MODE_PROG_WAIT, MODE_OFF, MODE_RESET: begin
				next_radio = 1'b0;
				next_pll = 1'b0;
			end
		endcase
		if (!active && mode != MODE_TEST) begin
			next_radio = 1'b0;
			next_pll = 1'b0;
		end
		next_qc = next_radio & ~o_radio_power_en;
		next_sync_valid = next_mode == MODE_LOCK;
		next_buzzer = (mode == MODE_TEST) ? pin_s2[4] : 1'b1;
		next_ref_div = (ref_div == REF_LAST) ? 11'h000 : 11'(ref_div + 1'b1);
		next_ref = (ref_div == REF_LAST) ? ~o_ref_clock_out : o_ref_clock_out;
		// Serial message shifter, MSB first, data changes while strobe is low
		next_ser_div = ser_tick ? 3'h0 : 3'(ser_div + 1'b1);
		next_ser_shift = ser_shift;
		next_ser_left = ser_left;
		next_msg_clk = o_msg_clk_out;
		fifo_out_ready = ser_left == '0 && mode != MODE_OFF;
		if (fifo_out_valid && fifo_out_ready) begin
			if ({cfg[FMT1_POS], cfg[FMT0_POS]} == 2'h0) begin
				next_ser_shift = fifo_out_data;
				next_ser_left = FULL_LEN;
			end else begin
				next_ser_shift = {fifo_out_data[30:11], 12'h000};
				next_ser_left = PAYLOAD_LEN;
			end
			next_msg_clk = 1'b0;
			next_ser_div = 3'h0; // First strobe rise a full half period after the data
		end else if (ser_left != '0 && ser_tick && mode != MODE_OFF) begin
			if (!o_msg_clk_out) begin
				next_msg_clk = 1'b1;
			end else begin
				next_msg_clk = 1'b0;
				next_ser_shift = {ser_shift[30:0], 1'b0};
				next_ser_left = 6'(ser_left - 1'b1);
			end
		end
		next_msg_out = (next_ser_left != '0) && next_ser_shift[31] && mode != MODE_OFF;
		if (mode == MODE_OFF) begin
			next_msg_clk = 1'b0;
		end
	end

	// State and output registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode <= MODE_PROG_WAIT;
			cfg <= '0;
			prog_cnt <= '0;
			rst_cnt <= '0;
			bit_div <= '0;
			bit_cnt <= '0;
			batch_cnt <= '0;
			sync_seen <= 1'b0;
			uncorr <= '0;
			in_msg <= 1'b0;
			term_pend <= 1'b0;
			push_valid <= 1'b0;
			push_data <= '0;
			ser_shift <= '0;
			ser_left <= '0;
			ser_div <= '0;
			ref_div <= '0;
			o_cw_ready <= 1'b0;
			o_radio_power_en <= 1'b0;
			o_radio_quick_charge <= 1'b0;
			o_pll_power_en <= 1'b0;
			o_addr_match_flag_n <= 1'b1;
			o_msg_serial_out <= 1'b0;
			o_msg_clk_out <= 1'b0;
			o_sync_valid_out <= 1'b0;
			o_buzzer_out <= 1'b1;
			o_ref_clock_out <= 1'b0;
		end else begin
			mode <= next_mode;
			cfg <= next_cfg;
			prog_cnt <= next_prog_cnt;
			rst_cnt <= next_rst_cnt;
			bit_div <= next_bit_div;
			bit_cnt <= next_bit_cnt;
			batch_cnt <= next_batch_cnt;
			sync_seen <= next_sync_seen;
			uncorr <= next_uncorr;
			in_msg <= next_in_msg;
			term_pend <= next_term_pend;
			push_valid <= next_push_valid;
			push_data <= next_push_data;
			ser_shift <= next_ser_shift;
			ser_left <= next_ser_left;
			ser_div <= next_ser_div;
			ref_div <= next_ref_div;
			o_cw_ready <= next_cw_ready;
			o_radio_power_en <= next_radio;
			o_radio_quick_charge <= next_qc;
			o_pll_power_en <= next_pll;
			o_addr_match_flag_n <= next_addr_n;
			o_msg_serial_out <= next_msg_out;
			o_msg_clk_out <= next_msg_clk;
			o_sync_valid_out <= next_sync_valid;
			o_buzzer_out <= next_buzzer;
			o_ref_clock_out <= next_ref;
		end
	end

	// Captured words wait here until the serial shifter takes them
	msg_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_in_valid(push_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data)
	);
endmodule : paging_mode_ctrl

// file: hdl/paging_pkg.sv
// Constants, field positions and mode codes of the paging decoder mode control.
// Assumes one 125 MHz system clock; all slower rates are enables derived from it.
package paging_pkg;
	// Clock and timing
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int BIT_RATE_BPS = 1200;
	localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
	localparam int RST_HOLD_US = 2000;
	localparam int RST_CYCLES = (CLK_HZ / 1_000_000) * RST_HOLD_US;
	localparam int REF_HZ = 32768;
	localparam int REF_HALF_CYCLES = CLK_HZ / (2 * REF_HZ);
	localparam int MSG_HALF_NS = 64;
	localparam int MSG_HALF_CYCLES = MSG_HALF_NS / CLK_PERIOD_NS;
	// Programming word
	localparam logic [7:0] PROG_BITS = 8'h80;
	localparam logic [7:0] PROG_LAST = 8'h7F;
	// Batch timing in bit periods; catch and hold lengths in batches
	localparam logic [9:0] BATCH_BITS = 10'h240;
	localparam logic [9:0] BATCH_LAST = 10'h23F;
	localparam logic [9:0] CATCH1_LAST = 10'h003;
	localparam logic [9:0] CATCH2_ON_BITS = 10'h0C0;
	localparam logic [9:0] IDLE_ON_BITS = 10'h020;
	localparam logic [9:0] HOLD_BASE = 10'h040;
	// Field positions in the address and option word
	localparam int ADDR_POS = 3;
	localparam int FRAME_POS = 21;
	localparam int ADDR_STEP = 32;
	localparam int OVER_POS = 28;
	localparam int EN_POS = 56;
	localparam int TD3_POS = 65;
	localparam int PL1_POS = 88;
	localparam int PL2_POS = 89;
	localparam int PL3_POS = 90;
	localparam int PL4_POS = 91;
	localparam int TD1_POS = 93;
	localparam int TD2_POS = 94;
	localparam int EOUTR_POS = 96;
	localparam int FMT0_POS = 120;
	localparam int FMT1_POS = 121;
	localparam int HOLD0_POS = 122;
	localparam int HOLD1_POS = 123;
	// Output stream
	localparam int WORD_BITS = 32;
	localparam int FIFO_DEPTH = 8;
	localparam logic [31:0] TERM_WORD = 32'hFFFF_FFFF;
	localparam logic [5:0] FULL_LEN = 6'h20;
	localparam logic [5:0] PAYLOAD_LEN = 6'h14;
	// Operating modes, Gray coded along the usual path
	typedef enum logic [2:0] {
		MODE_PROG_WAIT = 3'h0,
		MODE_OFF = 3'h1,
		MODE_CATCH1 = 3'h3,
		MODE_CATCH2 = 3'h2,
		MODE_IDLE = 3'h6,
		MODE_LOCK = 3'h7,
		MODE_RESET = 3'h5,
		MODE_TEST = 3'h4
	} mode_type;
endpackage : paging_pkg

// file: tb/host_model.sv
// Host processor model: programs the option word and collects message bits.
// Assumes the decoder clock on i_clk; pins change after its falling edge.
`timescale 1ns/100ps
module host_model (
	input wire logic i_clk,
	input wire logic i_msg_serial_out,
	input wire logic i_msg_clk_out,
	output logic o_prog_clk,
	output logic o_prog_serial_in
);
	logic [95:0] rx_bits;
	int rx_count;

	// Idle pins at time zero
	initial begin
		o_prog_clk = 1'b0;
		o_prog_serial_in = 1'b0;
		rx_bits = '0;
		rx_count = 0;
	end

	// Sends n strobes, bit k with strobe k; strobe period is 16 clocks (128 ns)
	task automatic send_word(input logic [127:0] word, input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge i_clk);
			o_prog_serial_in = word[k % 128];
			repeat (7) @(negedge i_clk);
			o_prog_clk = 1'b1;
			repeat (8) @(negedge i_clk);
			o_prog_clk = 1'b0;
		end
		o_prog_serial_in = ~o_prog_serial_in; // Released line shows no stale bit
	endtask : send_word

	// Takes each bit at the strobe's rising edge
	always @(posedge i_msg_clk_out) begin
		rx_bits = {rx_bits[94:0], i_msg_serial_out};
		rx_count = rx_count + 1;
	end
endmodule : host_model

// file: tb/paging_mode_ctrl_checker.sv
// Checker for the paging decoder mode control, watching the top module's ports.
// Assumes one clock domain on i_clk with the asynchronous reset i_rst_b.
`timescale 1ns/100ps
module paging_mode_ctrl_checker (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_cw_valid,
	input wire logic o_cw_ready,
	input wire logic o_radio_power_en,
	input wire logic o_radio_quick_charge,
	input wire logic o_pll_power_en,
	input wire logic o_addr_match_flag_n,
	input wire logic o_msg_serial_out,
	input wire logic o_msg_clk_out,
	input wire logic o_sync_valid_out,
	input wire logic o_buzzer_out,
	input wire logic o_ref_clock_out
);
	logic ref_last;
	logic [11:0] ref_run;
	logic [11:0] next_ref_run;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// Cycles since the reference clock last changed level
	always_comb begin
		next_ref_run = (o_ref_clock_out != ref_last) ? 12'h001 : ref_run + 12'h001;
	end

	// Registers the run length; one cycle of slack covers the reset release
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_last <= 1'b0;
			ref_run <= 12'h000;
		end else begin
			ref_last <= o_ref_clock_out;
			ref_run <= next_ref_run;
		end
	end

	// Quick charge is a single cycle pulse
	sequence s_qc_pulse;
		o_radio_quick_charge ##1 !o_radio_quick_charge;
	endsequence

	// Message strobe stays high for eight clocks
	sequence s_strobe_high;
		o_msg_clk_out [*8] ##1 !o_msg_clk_out;
	endsequence

	a_qc_on_rise: assert property ($rose(o_radio_power_en) |-> s_qc_pulse)
		else $error("quick charge pulse missing at radio enable");
	a_qc_has_cause: assert property (o_radio_quick_charge |-> $rose(o_radio_power_en))
		else $error("quick charge without radio enable rise");
	a_ready_in_lock: assert property (o_cw_ready |-> o_sync_valid_out)
		else $error("codeword ready outside lock");
	a_strobe_width: assert property ($rose(o_msg_clk_out) |-> s_strobe_high)
		else $error("message strobe width wrong");
	a_data_setup: assert property ($rose(o_msg_clk_out) |->
		$past(o_msg_serial_out, 8) == o_msg_serial_out)
		else $error("message data moved before strobe");
	a_pll_covers_radio: assert property (o_radio_power_en |-> o_pll_power_en)
		else $error("radio on while pll off");
	a_lock_full_on: assert property (o_sync_valid_out && $past(o_sync_valid_out)
		|-> o_radio_power_en && o_pll_power_en)
		else $error("radio or pll off in lock");
	a_flag_cause: assert property ($fell(o_addr_match_flag_n)
		|-> $past(i_cw_valid && o_cw_ready))
		else $error("address flag without accepted word");
	a_buzzer_in_test: assert property (!o_buzzer_out
		|-> !o_sync_valid_out && !o_msg_clk_out)
		else $error("buzzer low outside board test");
	a_ref_running: assert property (ref_run <= 12'h774)
		else $error("reference clock stopped");
endmodule : paging_mode_ctrl_checker

bind paging_mode_ctrl paging_mode_ctrl_checker paging_mode_ctrl_checker_inst (
	.i_clk, .i_rst_b, .i_cw_valid, .o_cw_ready, .o_radio_power_en,
	.o_radio_quick_charge, .o_pll_power_en, .o_addr_match_flag_n,
	.o_msg_serial_out, .o_msg_clk_out, .o_sync_valid_out, .o_buzzer_out,
	.o_ref_clock_out
);

// file: tb/paging_mode_ctrl_tb_top.sv
// Self-checking bench of the paging decoder mode control.
// Assumes shortened bit and reset counts; the bench plays the decoder core.
`timescale 1ns/100ps
module paging_mode_ctrl_tb_top;
	import paging_pkg::*;
	localparam int BITC = 8;
	localparam int BATCH = 576 * BITC;
	localparam int IDLE_RADIO = (32 + 6) * BITC; // Window plus radio pre-on
	localparam int IDLE_PLL = (32 + 6 + 16) * BITC; // Plus the pll lead
	localparam logic [17:0] ADDR = 18'h2A5C3;
	localparam logic [31:0] AW = {1'b0, ADDR, 13'h0000};
	localparam logic [31:0] MW = 32'h8123_4567;
	logic i_clk, i_rst_b, i_ext_reset_n, i_prog_clk, i_prog_serial_in;
	logic i_rx_enable, i_rx_bitstream_in, i_sync_hit, i_cw_valid, i_cw_uncorr;
	logic [31:0] i_cw_word;
	logic [2:0] i_cw_frame;
	logic o_cw_ready, o_radio_power_en, o_radio_quick_charge, o_pll_power_en;
	logic o_addr_match_flag_n, o_msg_serial_out, o_msg_clk_out, o_sync_valid_out;
	logic o_buzzer_out, o_ref_clock_out;
	logic [127:0] cfg;
	int n_mismatch = 0;
	int checked = 0;

	paging_mode_ctrl #(.P_BIT_CYCLES(BITC), .P_RST_CYCLES(16)) paging_mode_ctrl_inst (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ext_reset_n(i_ext_reset_n),
		.i_prog_clk(i_prog_clk), .i_prog_serial_in(i_prog_serial_in),
		.i_rx_enable(i_rx_enable), .i_rx_bitstream_in(i_rx_bitstream_in),
		.i_sync_hit(i_sync_hit), .i_cw_valid(i_cw_valid), .i_cw_word(i_cw_word),
		.i_cw_frame(i_cw_frame), .i_cw_uncorr(i_cw_uncorr), .o_cw_ready(o_cw_ready),
		.o_radio_power_en(o_radio_power_en), .o_radio_quick_charge(o_radio_quick_charge),
		.o_pll_power_en(o_pll_power_en), .o_addr_match_flag_n(o_addr_match_flag_n),
		.o_msg_serial_out(o_msg_serial_out), .o_msg_clk_out(o_msg_clk_out),
		.o_sync_valid_out(o_sync_valid_out), .o_buzzer_out(o_buzzer_out),
		.o_ref_clock_out(o_ref_clock_out));

	host_model host_model_inst (.i_clk(i_clk), .i_msg_serial_out(o_msg_serial_out),
		.i_msg_clk_out(o_msg_clk_out), .o_prog_clk(i_prog_clk),
		.o_prog_serial_in(i_prog_serial_in));

	// Clock of 8 ns period
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic end_sim();
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			n_mismatch++;
			end_sim();
		end
	endtask : tmo

	// Waits for the radio enable to reach a level, bounded
	task automatic wait_radio(input logic lvl, input int lim);
		int k;
		for (k = 0; k < lim && o_radio_power_en !== lvl; k++)
			@(negedge i_clk);
		tmo(k, lim);
	endtask : wait_radio

	// Offers one codeword and holds it until the edge that takes it
	task automatic send_cw(input logic [31:0] w, input logic [2:0] fr, input logic unc);
		int k;
		i_cw_word = w;
		i_cw_frame = fr;
		i_cw_uncorr = unc;
		i_cw_valid = 1'b1;
		for (k = 0; k < 2000 && o_cw_ready !== 1'b1; k++)
			@(negedge i_clk);
		tmo(k, 2000);
		@(negedge i_clk);
		i_cw_valid = 1'b0;
		@(negedge i_clk);
	endtask : send_cw

	task automatic t_prog_off();
		host_model_inst.send_word(cfg, 128);
		host_model_inst.send_word(~cfg, 5);
		repeat (20) @(negedge i_clk);
		check({o_radio_power_en, o_pll_power_en, o_sync_valid_out, o_msg_clk_out}, 4'h0);
		check({o_addr_match_flag_n, o_cw_ready, o_buzzer_out}, 3'h5);
	endtask : t_prog_off

	task automatic t_catch();
		int bad, nr, np;
		bad = 0;
		nr = 0;
		np = 0;
		i_rx_enable = 1'b1;
		wait_radio(1'b1, 20);
		repeat (4 * BATCH - 64) begin
			@(negedge i_clk);
			if ({o_radio_power_en, o_pll_power_en} !== 2'h3)
				bad++;
		end
		check(bad, 0);
		repeat (2 * BATCH + 200) @(negedge i_clk);
		repeat (BATCH) begin
			@(negedge i_clk);
			nr += o_radio_power_en;
			np += o_pll_power_en;
		end
		check(nr, IDLE_RADIO);
		check(np, IDLE_PLL);
	endtask : t_catch

	task automatic t_lock_msg();
		wait_radio(1'b0, BATCH);
		wait_radio(1'b1, BATCH);
		repeat (10 * BITC) @(negedge i_clk);
		i_sync_hit = 1'b1;
		@(negedge i_clk);
		i_sync_hit = 1'b0;
		repeat (4) @(negedge i_clk);
		check(o_sync_valid_out, 1'b1);
		send_cw(AW, 3'h1, 1'b0);
		repeat (4) @(negedge i_clk);
		check(o_addr_match_flag_n, 1'b1);
		send_cw(AW, 3'h0, 1'b0);
		check(o_addr_match_flag_n, 1'b0);
		send_cw(MW, 3'h0, 1'b0);
		send_cw(32'hC000_0001, 3'h0, 1'b1);
		for (int k = 0; k < 4000 && host_model_inst.rx_count < 96; k++)
			@(negedge i_clk);
		repeat (40) @(negedge i_clk);
		check(host_model_inst.rx_count, 96);
		check(host_model_inst.rx_bits, {AW, MW, TERM_WORD});
		check(o_addr_match_flag_n, 1'b1);
	endtask : t_lock_msg

	task automatic t_rx_off();
		i_rx_enable = 1'b0;
		repeat (10) @(negedge i_clk);
		check({o_radio_power_en, o_pll_power_en, o_sync_valid_out}, 3'h0);
		i_rx_enable = 1'b1;
		wait_radio(1'b1, 20);
	endtask : t_rx_off

	task automatic t_reset_test();
		i_ext_reset_n = 1'b0;
		repeat (40) @(negedge i_clk);
		check({o_radio_power_en, o_pll_power_en}, 2'h3);
		i_rx_bitstream_in = 1'b0;
		repeat (8) @(negedge i_clk);
		check(o_buzzer_out, 1'b0);
		i_rx_bitstream_in = 1'b1;
		repeat (8) @(negedge i_clk);
		check(o_buzzer_out, 1'b1);
		i_rx_enable = 1'b0;
		repeat (10) @(negedge i_clk);
		check({o_radio_power_en, o_pll_power_en}, 2'h0);
		i_ext_reset_n = 1'b1;
		repeat (40) @(negedge i_clk);
		i_rx_enable = 1'b1;
		repeat (20) @(negedge i_clk);
		check(o_radio_power_en, 1'b0);
		host_model_inst.send_word(cfg, 128);
		wait_radio(1'b1, 20);
	endtask : t_reset_test

	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge i_clk);
		n_mismatch++;
		end_sim();
	end

	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		i_ext_reset_n = 1'b1;
		i_rx_enable = 1'b0;
		i_rx_bitstream_in = 1'b1;
		i_sync_hit = 1'b0;
		i_cw_valid = 1'b0;
		i_cw_word = 32'h0000_0000;
		i_cw_frame = 3'h0;
		i_cw_uncorr = 1'b0;
		cfg = '0;
		for (int i = 0; i < 18; i++)
			cfg[ADDR_POS + i] = ADDR[17 - i];
		cfg[EN_POS] = 1'b1;
		cfg[TD3_POS] = 1'b1;
		cfg[PL1_POS] = 1'b1;
		cfg[PL3_POS] = 1'b1;
		repeat (20) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_prog_off();
		t_catch();
		t_lock_msg();
		t_rx_off();
		t_reset_test();
		end_sim();
	end
endmodule : paging_mode_ctrl_tb_top
